// file: hw/sles_top.sv
// Serial lane error status register bank: per-lane error counters and link status over APB.
// Assumes error strobes and lane states come from decoder logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module sles_top #(
  parameter int unsigned NUM_LANES = sles_pkg::NUM_LANES,
  parameter int unsigned NUM_LINKS = sles_pkg::NUM_LINKS
) (
  input  wire logic                          clk_i,
  input  wire logic                          rstn_i,
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [15:0]                   paddr_i,
  input  wire logic [31:0]                   pwdata_i,
  input  wire logic [3:0]                    pstrb_i,
  output logic                               pready_o,
  output logic      [31:0]                   prdata_o,
  output logic                               pslverr_o,
  input  wire sles_pkg::sles_err_type        err_i   [NUM_LINKS][NUM_LANES],
  input  wire sles_pkg::sles_lane_state_type state_i [NUM_LINKS][NUM_LANES],
  output logic                               irq_o
);

  localparam int unsigned PW = (NUM_LINKS > 1) ? $clog2(NUM_LINKS) : 1;
  localparam int unsigned NW = NUM_LINKS * NUM_LANES;

  sles_pkg::sles_cnt_type cnt_q [NUM_LINKS][NUM_LANES];
  logic [PW-1:0]  page_q;
  logic [7:0]     thresh_q;
  logic           hold_q;
  logic [NW-1:0]  irq_stat_q;
  logic [NW-1:0]  irq_mask_q;
  logic [NW-1:0]  tc_event;
  logic [31:0]    rdata_d;
  logic [31:0]    prdata_q;

  // Bus decode. The slave answers in the first access cycle, with no wait states.
  wire              acc     = psel_i && penable_i;
  wire              wr_acc  = acc && pwrite_i;
  wire              aligned = (paddr_i[1:0] == 2'b00);
  wire [13:0]       idx     = paddr_i[15:2];
  wire              in_ecnt = (idx >= 14'(sles_pkg::IDX_ECNT_STAT0))
                              && (idx < 14'(sles_pkg::IDX_ECNT_STAT0) + 14'(NUM_LANES));
  wire              in_link = (idx >= 14'(sles_pkg::IDX_LINK_STAT0))
                              && (idx < 14'(sles_pkg::IDX_LINK_STAT0) + 14'(NUM_LANES));
  wire              hit_page  = idx == 14'(sles_pkg::IDX_LINK_PAGE);
  wire              hit_thr   = idx == 14'(sles_pkg::IDX_THRESHOLD);
  wire              hit_hold  = idx == 14'(sles_pkg::IDX_HOLD_EN);
  wire              hit_clr   = idx == 14'(sles_pkg::IDX_CNT_CLEAR);
  wire              hit_ista  = idx == 14'(sles_pkg::IDX_IRQ_STATUS);
  wire              hit_imsk  = idx == 14'(sles_pkg::IDX_IRQ_MASK);
  wire              mapped    = aligned && (in_ecnt || in_link || hit_page || hit_thr
                                || hit_hold || hit_clr || hit_ista || hit_imsk);
  wire [2:0]        lane_sel  = in_ecnt ? 3'(idx - 14'(sles_pkg::IDX_ECNT_STAT0))
                                        : 3'(idx - 14'(sles_pkg::IDX_LINK_STAT0));
  wire              lo_lane   = wr_acc && pstrb_i[0];
  wire              clr_wr    = lo_lane && aligned && hit_clr;
  // Each counter clear write zeroes all counters of the paged link whose bit is set.
  wire [NUM_LANES-1:0] clr_lane = clr_wr ? pwdata_i[NUM_LANES-1:0] : '0;

  assign pready_o  = 1'b1;
  assign pslverr_o = acc && !mapped;
  assign prdata_o  = prdata_q;

  // Paged view of the selected lane for reads.
  sles_pkg::sles_cnt_type        sel_cnt;
  sles_pkg::sles_lane_state_type sel_st;
  assign sel_cnt = cnt_q[page_q][lane_sel];
  assign sel_st  = state_i[page_q][lane_sel];

  wire [2:0] sel_tc = {sel_cnt.stray == sles_pkg::TERMINAL_COUNT,
                       sel_cnt.table_miss == sles_pkg::TERMINAL_COUNT,
                       sel_cnt.disp == sles_pkg::TERMINAL_COUNT};
  wire [7:0] ecnt_word = {4'h0, sel_st.active, sel_tc};
  wire [7:0] link_word = {sel_cnt.disp >= thresh_q,
                          sel_cnt.table_miss >= thresh_q,
                          sel_cnt.stray >= thresh_q,
                          sel_st.deskew_ok,
                          sel_st.sync_ok,
                          3'h0};

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (in_ecnt) begin
      rdata_d = {24'h0, ecnt_word};
    end else if (in_link) begin
      rdata_d = {24'h0, link_word};
    end else if (hit_page) begin
      rdata_d = 32'(page_q);
    end else if (hit_thr) begin
      rdata_d = {24'h0, thresh_q};
    end else if (hit_hold) begin
      rdata_d = {31'h0, hold_q};
    end else if (hit_ista) begin
      rdata_d = 32'(irq_stat_q);
    end else if (hit_imsk) begin
      rdata_d = 32'(irq_mask_q);
    end
  end

  // Read data is registered at the setup cycle so it is stable throughout the access.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_q <= mapped ? rdata_d : 32'h0000_0000;
    end
  end

  // Control registers; counter and link status registers take no write at all.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      page_q   <= '0;
      thresh_q <= sles_pkg::THRESH_RESET;
      hold_q   <= 1'b0;
    end else if (lo_lane && aligned) begin
      if (hit_page) begin
        page_q <= pwdata_i[PW-1:0];
      end
      if (hit_thr) begin
        thresh_q <= pwdata_i[7:0];
      end
      if (hit_hold) begin
        hold_q <= pwdata_i[0];
      end
    end
  end

  // Per-lane counters, one generate entry per link and lane.
  for (genvar k = 0; k < NUM_LINKS; k++) begin : g_link
    for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
      localparam int unsigned N = k * NUM_LANES + l;
      wire clr = clr_lane[l] && (page_q == PW'(k));
      wire at_tc = (cnt_q[k][l].disp == sles_pkg::TERMINAL_COUNT)
                   || (cnt_q[k][l].table_miss == sles_pkg::TERMINAL_COUNT)
                   || (cnt_q[k][l].stray == sles_pkg::TERMINAL_COUNT);
      // A held counter freezes at terminal count; an unheld one wraps.
      wire stop_d = hold_q && (cnt_q[k][l].disp == sles_pkg::TERMINAL_COUNT);
      wire stop_t = hold_q && (cnt_q[k][l].table_miss == sles_pkg::TERMINAL_COUNT);
      wire stop_s = hold_q && (cnt_q[k][l].stray == sles_pkg::TERMINAL_COUNT);
      wire inc_d  = err_i[k][l].disparity_error && !stop_d;
      wire inc_t  = err_i[k][l].table_miss_error && !stop_t;
      wire inc_s  = err_i[k][l].stray_control_char_error && !stop_s;
      logic at_tc_q;
      assign tc_event[N] = at_tc && !at_tc_q;

      always_ff @(posedge clk_i) begin
        if (!rstn_i || clr) begin
          cnt_q[k][l] <= '0;
          at_tc_q     <= 1'b0;
        end else begin
          at_tc_q <= at_tc;
          if (inc_d) begin
            cnt_q[k][l].disp <= cnt_q[k][l].disp + 8'h01;
          end
          if (inc_t) begin
            cnt_q[k][l].table_miss <= cnt_q[k][l].table_miss + 8'h01;
          end
          if (inc_s) begin
            cnt_q[k][l].stray <= cnt_q[k][l].stray + 8'h01;
          end
        end
      end
    end
  end

  // Interrupt status: set wins over a write-one clear arriving in the same cycle.
  wire [NW-1:0] ista_clr = (lo_lane && aligned && hit_ista) ? pwdata_i[NW-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~ista_clr) | tc_event;
      if (lo_lane && aligned && hit_imsk) begin
        irq_mask_q <= pwdata_i[NW-1:0];
      end
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // The counter assertions watch lane 7 of link 0, the lane that is driven to terminal count.
  // Watching one lane keeps the checks cheap; the generate loop makes the others alike.
  wire [7:0] cd       = cnt_q[0][7].disp;
  wire [7:0] ct       = cnt_q[0][7].table_miss;
  wire [7:0] cs       = cnt_q[0][7].stray;
  wire       clr7     = clr_lane[7] && (page_q == '0);
  wire       rd_setup = psel_i && !penable_i && !pwrite_i && aligned;
  wire       ctl_wr   = lo_lane && aligned;

  hold_stray_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    hold_q && cs == 8'hff && !clr7
    |=> cs == 8'hff)
    else $error("held counter left terminal count");

  hold_disp_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    hold_q && cd == 8'hff && !clr7
    |=> cd == 8'hff)
    else $error("held disparity counter left terminal count");

  wrap_tc_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !hold_q && cd == 8'hff && err_i[0][7].disparity_error && !clr7
    |=> cd == 8'h00)
    else $error("unheld counter did not wrap");

  wrap_table_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !hold_q && ct == 8'hff && err_i[0][7].table_miss_error && !clr7
    |=> ct == 8'h00)
    else $error("unheld table counter did not wrap");

  count_inc_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cd != 8'hff && err_i[0][7].disparity_error && !clr7
    |=> cd == $past(cd) + 8'h01)
    else $error("counter missed an error");

  table_inc_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ct != 8'hff && err_i[0][7].table_miss_error && !clr7
    |=> ct == $past(ct) + 8'h01)
    else $error("table counter missed an error");

  stray_inc_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cs != 8'hff && err_i[0][7].stray_control_char_error && !clr7
    |=> cs == $past(cs) + 8'h01)
    else $error("stray counter missed an error");

  count_idle_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !err_i[0][7].disparity_error && !clr_wr
    |=> $stable(cd))
    else $error("counter moved without an error");

  clear_zero_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    clr7
    |=> cd == 8'h00 && ct == 8'h00 && cs == 8'h00)
    else $error("counter clear left a count");

  tc_flag_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_setup && in_ecnt
    |=> prdata_o[0] == ($past(sel_cnt.disp) == 8'hff))
    else $error("terminal flag wrong");

  tc_order_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_setup && in_ecnt
    |=> prdata_o[2:1] == {$past(sel_cnt.stray) == 8'hff, $past(sel_cnt.table_miss) == 8'hff})
    else $error("terminal flag order wrong");

  ecnt_rsvd_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_setup && in_ecnt
    |=> prdata_o[31:4] == 28'h0)
    else $error("counter status reserved bits set");

  lane_act_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_setup && in_ecnt
    |=> prdata_o[3] == $past(sel_st.active))
    else $error("lane active bit wrong");

  thresh_cmp_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_setup && in_link
    |=> prdata_o[7] == ($past(sel_cnt.disp) >= $past(thresh_q)))
    else $error("threshold status bit wrong");

  table_cmp_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_setup && in_link
    |=> prdata_o[6] == ($past(sel_cnt.table_miss) >= $past(thresh_q)))
    else $error("table threshold bit wrong");

  stray_cmp_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_setup && in_link
    |=> prdata_o[5] == ($past(sel_cnt.stray) >= $past(thresh_q)))
    else $error("stray threshold bit wrong");

  link_rsvd_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_setup && in_link
    |=> prdata_o[2:0] == 3'h0 && prdata_o[31:8] == 24'h0)
    else $error("link status spare bits set");

  deskew_bit_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_setup && in_link
    |=> prdata_o[4] == $past(sel_st.deskew_ok))
    else $error("deskew bit wrong");

  sync_bit_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_setup && in_link
    |=> prdata_o[3] == $past(sel_st.sync_ok))
    else $error("lane sync bit wrong");

  page_view_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    rd_setup && in_link && lane_sel == 3'h1 && page_q == PW'(1)
    |=> prdata_o[3] == $past(state_i[1][1].sync_ok))
    else $error("paged read shows the wrong link");

  thr_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ctl_wr && hit_thr
    |=> thresh_q == $past(pwdata_i[7:0]))
    else $error("threshold write lost");

  ro_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ctl_wr && (in_ecnt || in_link)
    |=> $stable(page_q) && $stable(thresh_q) && $stable(hold_q) && $stable(irq_mask_q))
    else $error("status write changed a register");

  tc_irq_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tc_event[7]
    |=> irq_stat_q[7])
    else $error("terminal event lost");

  irq_clr_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ista_clr[7] && !tc_event[7]
    |=> !irq_stat_q[7])
    else $error("interrupt status not cleared");

  irq_level_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    irq_o == |(irq_stat_q & irq_mask_q))
    else $error("interrupt level wrong");

  slverr_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    acc && !aligned
    |-> pslverr_o)
    else $error("unaligned access not refused");

  cv_wrap_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
    cd == 8'hff ##1 cd == 8'h00);

  cv_hold_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
    hold_q && cs == 8'hff && err_i[0][7].stray_control_char_error);

  cv_irq_c: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(irq_o));

  cv_page_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
    rd_setup && in_link && page_q == PW'(1));

  cv_thr_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
    rd_setup && in_link && thresh_q == 8'h03);

endmodule

`default_nettype wire

// file: pkg/sles_pkg.sv
// Package for the serial lane error status register bank.
// Assumes a 32-bit APB slave with word-aligned registers and one clock.
package sles_pkg;

  localparam int unsigned NUM_LANES  = 8;
  localparam int unsigned NUM_LINKS  = 2;
  localparam int unsigned CNT_W      = 8;
  localparam int unsigned ADDR_W     = 12;

  // Printed offsets are not multiples of four, so they are indices; byte address is four times.
  localparam logic [ADDR_W-1:0] IDX_LINK_PAGE   = 12'h300;
  localparam logic [ADDR_W-1:0] IDX_ECNT_STAT0  = 12'h490;
  localparam logic [ADDR_W-1:0] IDX_LANE7_ECNT  = 12'h497;
  localparam logic [ADDR_W-1:0] IDX_LINK_STAT0  = 12'h4b0;
  localparam logic [ADDR_W-1:0] IDX_LANE0_LINK  = 12'h4b0;
  localparam logic [ADDR_W-1:0] IDX_THRESHOLD   = 12'h4c0;
  localparam logic [ADDR_W-1:0] IDX_HOLD_EN     = 12'h4c1;
  localparam logic [ADDR_W-1:0] IDX_CNT_CLEAR   = 12'h4c2;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS  = 12'h4c3;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK    = 12'h4c4;

  // Counter status fields.
  localparam int unsigned TC_DISP_BIT   = 0;
  localparam int unsigned TC_TABLE_BIT  = 1;
  localparam int unsigned TC_STRAY_BIT  = 2;
  localparam int unsigned LANE_ACT_BIT  = 3;
  // Link status fields.
  localparam int unsigned LS_SYNC_BIT   = 3;
  localparam int unsigned LS_DESKEW_BIT = 4;
  localparam int unsigned LS_STRAY_BIT  = 5;
  localparam int unsigned LS_TABLE_BIT  = 6;
  localparam int unsigned LS_DISP_BIT   = 7;

  localparam logic [7:0] TERMINAL_COUNT = 8'hff;
  localparam logic [7:0] THRESH_RESET   = 8'hff;
  localparam logic [7:0] REG_RESET      = 8'h00;

  typedef struct packed {
    logic stray_control_char_error;
    logic table_miss_error;
    logic disparity_error;
  } sles_err_type;

  typedef struct packed {
    logic active;
    logic deskew_ok;
    logic sync_ok;
  } sles_lane_state_type;

  typedef struct packed {
    logic [CNT_W-1:0] stray;
    logic [CNT_W-1:0] table_miss;
    logic [CNT_W-1:0] disp;
  } sles_cnt_type;

endpackage

// file: bench/sles_lane_tx_model.sv
// Behavioural model of the serial link transmitter and lane decoders feeding the block.
// Assumes the bench calls its tasks from one process that follows clk_i.
`timescale 1ns/1ps
`default_nettype none

module sles_lane_tx_model (
  input  wire logic                         clk_i,
  output var sles_pkg::sles_err_type        err_o   [sles_pkg::NUM_LINKS][sles_pkg::NUM_LANES],
  output var sles_pkg::sles_lane_state_type state_o [sles_pkg::NUM_LINKS][sles_pkg::NUM_LANES]
);
  initial begin
    foreach (err_o[k, l]) begin
      err_o[k][l]   = '0;
      state_o[k][l] = '0;
    end
  end

  // Every edge that sees a strobe high is one error, so a burst needs no idle gaps.
  task automatic burst(input int link, input int lane, input logic [2:0] kinds, input int n);
    @(posedge clk_i);
    err_o[link][lane] <= kinds;
    repeat (n) @(posedge clk_i);
    err_o[link][lane] <= '0;
  endtask

  task automatic set_state(input int link, input int lane, input logic [2:0] st);
    @(posedge clk_i);
    state_o[link][lane] <= st;
  endtask
endmodule

`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the lane error status bank.
// Assumes the transmitter model drives the error strobes and lane states.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        clk_i, rstn_i, psel, penable, pwrite, pready, pslverr, irq, se;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cycles = 0;
  sles_pkg::sles_err_type        err   [sles_pkg::NUM_LINKS][sles_pkg::NUM_LANES];
  sles_pkg::sles_lane_state_type state [sles_pkg::NUM_LINKS][sles_pkg::NUM_LANES];
  localparam logic [11:0] ECNT7 = sles_pkg::IDX_LANE7_ECNT;
  localparam logic [11:0] LINK0 = sles_pkg::IDX_LINK_STAT0;

  sles_top i_sles_top (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .err_i(err), .state_i(state), .irq_o(irq));
  sles_lane_tx_model i_sles_lane_tx_model (.clk_i(clk_i), .err_o(err), .state_o(state));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic results();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // The run needs about 1200 cycles, so a hang is cut well before the budget.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [11:0] idx, input logic wr, input logic [31:0] wd);
    @(posedge clk_i);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    xfer(idx, 1'b1, d);
  endtask

  task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
    xfer(idx, 1'b0, 32'h0);
    chk(rd, exp);
  endtask

  task automatic irq_chk(input logic exp);
    @(negedge clk_i);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic t_reset();
    rd_chk(ECNT7, 32'h0);
    rd_chk(LINK0, 32'h0);
    rd_chk(sles_pkg::IDX_THRESHOLD, 32'hff);
    wr(12'h100, 32'h1);
    chk({31'h0, se}, 32'h1);
  endtask

  task automatic t_state();
    i_sles_lane_tx_model.set_state(0, 7, 3'b100);
    rd_chk(ECNT7, 32'h08);
    i_sles_lane_tx_model.set_state(0, 7, 3'b000);
    i_sles_lane_tx_model.set_state(0, 0, 3'b011);
    rd_chk(LINK0, 32'h18);
    i_sles_lane_tx_model.set_state(0, 0, 3'b010);
    rd_chk(LINK0, 32'h10);
    i_sles_lane_tx_model.set_state(0, 0, 3'b001);
    rd_chk(LINK0, 32'h08);
    i_sles_lane_tx_model.set_state(0, 0, 3'b000);
  endtask

  task automatic t_thresh();
    wr(sles_pkg::IDX_THRESHOLD, 32'h3);
    i_sles_lane_tx_model.burst(0, 0, 3'b001, 2);
    rd_chk(LINK0, 32'h0);
    i_sles_lane_tx_model.burst(0, 0, 3'b001, 1);
    rd_chk(LINK0, 32'h80);
    i_sles_lane_tx_model.burst(0, 0, 3'b010, 3);
    rd_chk(LINK0, 32'hc0);
    i_sles_lane_tx_model.burst(0, 0, 3'b100, 3);
    rd_chk(LINK0, 32'he0);
    wr(sles_pkg::IDX_THRESHOLD, 32'h4);
    rd_chk(LINK0, 32'h0);
    wr(sles_pkg::IDX_THRESHOLD, 32'h3);
  endtask

  task automatic t_terminal();
    wr(sles_pkg::IDX_HOLD_EN, 32'h1);
    i_sles_lane_tx_model.burst(0, 7, 3'b100, 254);
    rd_chk(ECNT7, 32'h0);
    i_sles_lane_tx_model.burst(0, 7, 3'b100, 1);
    rd_chk(ECNT7, 32'h04);
    i_sles_lane_tx_model.burst(0, 7, 3'b100, 5);
    rd_chk(ECNT7, 32'h04);
    i_sles_lane_tx_model.burst(0, 7, 3'b001, 255);
    rd_chk(ECNT7, 32'h05);
    i_sles_lane_tx_model.burst(0, 7, 3'b010, 255);
    rd_chk(ECNT7, 32'h07);
    rd_chk(sles_pkg::IDX_IRQ_STATUS, 32'h80);
    irq_chk(1'b0);
    wr(sles_pkg::IDX_IRQ_MASK, 32'h80);
    irq_chk(1'b1);
    wr(sles_pkg::IDX_IRQ_STATUS, 32'h80);
    irq_chk(1'b0);
    wr(sles_pkg::IDX_HOLD_EN, 32'h0);
    wr(sles_pkg::IDX_CNT_CLEAR, 32'h80);
    rd_chk(ECNT7, 32'h0);
    i_sles_lane_tx_model.burst(0, 7, 3'b001, 255);
    rd_chk(ECNT7, 32'h01);
    i_sles_lane_tx_model.burst(0, 7, 3'b001, 1);
    rd_chk(ECNT7, 32'h0);
    i_sles_lane_tx_model.burst(0, 7, 3'b001, 3);
    rd_chk(LINK0 + 12'h7, 32'h80);
  endtask

  task automatic t_page();
    i_sles_lane_tx_model.burst(1, 1, 3'b001, 3);
    i_sles_lane_tx_model.set_state(1, 1, 3'b001);
    rd_chk(LINK0 + 12'h1, 32'h0);
    wr(sles_pkg::IDX_LINK_PAGE, 32'h1);
    rd_chk(LINK0 + 12'h1, 32'h88);
    rd_chk(LINK0, 32'h0);
    wr(sles_pkg::IDX_LINK_PAGE, 32'h0);
  endtask

  task automatic t_wr_ignored();
    wr(LINK0, 32'hff);
    rd_chk(LINK0, 32'he0);
    wr(ECNT7, 32'hff);
    rd_chk(ECNT7, 32'h0);
  endtask

  initial begin
    rstn_i  = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 16'h0;
    pwdata  = 32'h0;
    pstrb   = 4'hf;
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_state();
    t_thresh();
    t_terminal();
    t_page();
    t_wr_ignored();
    results();
  end
endmodule

`default_nettype wire
